// >>> hnlc_codec.sv
`timescale 1ns/100ps
module hnlc_codec
    import hnlc_pkg::*;
#(
    parameter longint XMIT_LIMIT = XMIT_LIMIT_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic rx_bit,
    input wire logic rx_last,
    input wire logic rx_host_error,
    output logic tx_valid,
    output logic tx_bit,
    output logic tx_last,
    input wire logic tx_ready,
    output logic node_ready,
    output logic node_error
);
    // ****************************************
    // registers
    // ****************************************
    logic [95:0] rx_sr_reg;
    logic [95:0] rx_leader_reg;
    logic [95:0] tx_leader_reg;
    logic [95:0] tx_sr_reg;
    logic [6:0] rx_cnt_reg;
    logic [6:0] tx_cnt_reg;
    logic [15:0] body_cnt_reg;
    logic [39:0] timer_reg;
    logic [7:0] local_host_reg;
    logic [15:0] local_node_reg;
    logic [7:0] event_reg;
    logic [7:0] event_next;
    logic error_reg;
    logic ready_reg;
    logic tx_busy_reg;
    logic dead_pending_reg;
    logic [95:0] dead_leader_reg;
    logic [3:0] dead_sub_reg;
    hnlc_rx_t rx_state_reg;
    logic [95:0] auto_leader;
    logic auto_go;
    logic wr;
    logic rd;
    logic [95:0] rx_full;
    logic [7:0] lt;
    logic [3:0] lsub;
    logic too_many;
    logic lead_err_reg;
    logic reset_pending_reg;
    logic [95:0] end_leader;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign node_ready = ready_reg;
    assign node_error = error_reg;
    assign rx_full = {rx_sr_reg[94:0], rx_bit};

    // field view of a leader; index 95 holds bit 1
    function automatic logic [95:0] put(input logic [95:0] l, input int hi, input int w,
                                        input logic [15:0] v);
        logic [95:0] r;
        r = l;
        for (int i = 0; i < w; i++) begin
            r[96 - hi - i] = v[w - 1 - i];
        end
        return r;
    endfunction

    function automatic logic [15:0] get(input logic [95:0] l, input int hi, input int w);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < w; i++) begin
            r[w - 1 - i] = l[96 - hi - i];
        end
        return r;
    endfunction

    function automatic logic [95:0] reply(input logic [95:0] src, input logic [7:0] t,
                                          input logic [3:0] s);
        logic [95:0] r;
        r = '0;
        r = put(r, BIT_FMT_HI, 4, 16'(NEW_FORMAT));
        r = put(r, BIT_TYPE_HI, 8, 16'(t));
        r = put(r, BIT_PRIO, 8, get(src, BIT_PRIO, 8));
        r = put(r, BIT_HOST_HI, 8, get(src, BIT_HOST_HI, 8));
        r = put(r, BIT_NODE_HI, 16, get(src, BIT_NODE_HI, 16));
        r = put(r, BIT_MSGID_HI, 12, get(src, BIT_MSGID_HI, 12));
        r = put(r, BIT_SUB_HI, 4, 16'(s));
        return r;
    endfunction

    // a leader-only message ends before the leader register is loaded
    assign end_leader = (rx_state_reg == HNLC_BODY) ? rx_leader_reg : rx_full;
    assign lt = 8'(get(end_leader, BIT_TYPE_HI, 8));
    assign lsub = 4'(get(rx_leader_reg, BIT_SUB_HI, 4));
    assign too_many = body_cnt_reg >= 16'(PACKET_BITS * (DEFAULT_SIZE_CODE + 1));

    // ****************************************
    // receive state machine
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_state_reg <= HNLC_IDLE;
            rx_sr_reg <= '0;
            rx_cnt_reg <= '0;
            body_cnt_reg <= '0;
            timer_reg <= '0;
            rx_leader_reg <= '0;
            lead_err_reg <= 1'b0;
        end else begin
            case (rx_state_reg)
                HNLC_IDLE, HNLC_LEADER: begin
                    if (rx_valid) begin
                        rx_sr_reg <= rx_full;
                        rx_cnt_reg <= rx_cnt_reg + 7'h01;
                        rx_state_reg <= HNLC_LEADER;
                        if (rx_cnt_reg == 7'(LEADER_BITS - 1)) begin
                            rx_leader_reg <= rx_full;
                            rx_cnt_reg <= '0;
                            body_cnt_reg <= '0;
                            timer_reg <= '0;
                            lead_err_reg <= error_reg;
                            rx_state_reg <= rx_last ? HNLC_IDLE : HNLC_BODY;
                        end else if (rx_last) begin
                            rx_cnt_reg <= '0;
                            rx_state_reg <= HNLC_IDLE;
                        end
                    end
                end
                HNLC_BODY: begin
                    timer_reg <= timer_reg + 40'h1;
                    if (rx_valid) begin
                        body_cnt_reg <= body_cnt_reg + 16'h1;
                    end
                    if (rx_valid && rx_last) begin
                        rx_state_reg <= HNLC_IDLE;
                        body_cnt_reg <= '0;
                        timer_reg <= '0;
                    end
                end
                default: begin
                    if (rx_valid && rx_last) begin
                        rx_state_reg <= HNLC_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // error flag and ready line
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            error_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            if (rx_valid && rx_last && rx_state_reg != HNLC_DROP) begin
                error_reg <= 1'b0;
            end
            if (wr && paddr == A_CTRL) begin
                ready_reg <= pwdata[0];
                if (ready_reg && !pwdata[0]) begin
                    error_reg <= 1'b1;
                end
            end
            if (rx_host_error) begin
                error_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // automatic replies from received messages
    // ****************************************
    always_comb begin
        auto_go = 1'b0;
        auto_leader = '0;
        event_next = 8'h00;
        if (rx_valid && rx_last && rx_state_reg != HNLC_BODY &&
                rx_cnt_reg != 7'(LEADER_BITS - 1)) begin
            auto_go = 1'b1;
            if (error_reg) begin
                auto_leader = reply('0, T_ERR_LEADER, 4'h0);
            end else if (rx_cnt_reg < 7'(SHORT_BITS - 1)) begin
                auto_leader = reply('0, T_ERR_LEADER, 4'h1);
            end else begin
                auto_leader = reply('0, T_ERR_LEADER, 4'h0);
            end
            event_next[0] = 1'b1;
        end else if (rx_valid && rx_last) begin
            event_next[1] = 1'b1;
            if (lt != T_REGULAR && lt != T_ERR_LEADER && lt != T_GOING_DOWN &&
                    lt != T_NOP && lt != T_ERR_DATA) begin
                auto_go = 1'b1;
                auto_leader = reply(end_leader, T_ERR_LEADER, 4'h2);
            end else if (rx_state_reg == HNLC_BODY ? lead_err_reg : error_reg) begin
                // flag raised during the leader: leader counts as garbled
                auto_go = 1'b1;
                auto_leader = reply('0, T_ERR_LEADER, 4'h0);
            end else if (error_reg) begin
                auto_go = 1'b1;
                auto_leader = reply(rx_leader_reg, T_ERR_DATA, lsub);
            end else if (lt == T_REGULAR && timer_reg > 40'(XMIT_LIMIT)) begin
                auto_go = 1'b1;
                auto_leader = reply(rx_leader_reg, T_INCOMPLETE, 4'h2);
            end else if (lt == T_REGULAR && too_many) begin
                // size field ignored, eight packets applied
                auto_go = 1'b1;
                auto_leader = reply(rx_leader_reg, T_INCOMPLETE, 4'h1);
            end
        end
        if (rx_host_error) begin
            event_next[2] = 1'b1;
        end
    end

    // ****************************************
    // transmit: software or automatic leader
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_busy_reg <= 1'b0;
            tx_sr_reg <= '0;
            tx_cnt_reg <= '0;
            tx_leader_reg <= '0;
            dead_pending_reg <= 1'b0;
            dead_leader_reg <= '0;
            dead_sub_reg <= '0;
            reset_pending_reg <= 1'b0;
            local_host_reg <= '0;
            local_node_reg <= '0;
        end else begin
            if (wr && paddr == A_LOCAL) begin
                local_host_reg <= pwdata[23:16];
                local_node_reg <= pwdata[15:0];
            end
            if (wr && paddr == A_TX_W0) begin
                tx_leader_reg[95:64] <= pwdata;
            end
            if (wr && paddr == A_TX_W1) begin
                tx_leader_reg[63:32] <= pwdata;
            end
            if (wr && paddr == A_TX_W2) begin
                tx_leader_reg[31:0] <= pwdata;
            end
            if (tx_busy_reg && tx_ready) begin
                tx_sr_reg <= {tx_sr_reg[94:0], 1'b0};
                tx_cnt_reg <= tx_cnt_reg + 7'h01;
                if (tx_cnt_reg == 7'(LEADER_BITS - 1)) begin
                    tx_busy_reg <= 1'b0;
                    tx_cnt_reg <= '0;
                end
            end
            if (!ready_reg && tx_busy_reg) begin
                tx_busy_reg <= 1'b0;
                tx_cnt_reg <= '0;
            end
            if (!tx_busy_reg && ready_reg) begin
                if (reset_pending_reg) begin
                    tx_sr_reg <= reply('0, T_IF_RESET, 4'h0);
                    reset_pending_reg <= 1'b0;
                    tx_busy_reg <= 1'b1;
                end else if (auto_go) begin
                    tx_sr_reg <= auto_leader;
                    tx_busy_reg <= 1'b1;
                end else if (dead_pending_reg) begin
                    tx_sr_reg <= put(reply(dead_leader_reg, T_DEAD_STATUS, dead_sub_reg),
                                     BIT_PRIO, 1, 16'h0);
                    dead_pending_reg <= 1'b0;
                    tx_busy_reg <= 1'b1;
                end else if (wr && paddr == A_CMD) begin
                    tx_busy_reg <= 1'b1;
                    case (pwdata[3:0])
                        4'h0: tx_sr_reg <= tx_leader_reg;
                        4'h1: tx_sr_reg <= put(put(reply('0, T_NOP, 4'h0), BIT_HOST_HI, 8,
                                               16'(local_host_reg)), BIT_NODE_HI, 16,
                                               local_node_reg);
                        4'h2: tx_sr_reg <= reply(rx_leader_reg, T_ACK,
                                                 {3'h0, lsub == 4'h1});
                        4'h3: tx_sr_reg <= reply(rx_leader_reg, T_REFUSED, pwdata[7:4]);
                        default: tx_sr_reg <= reply(rx_leader_reg, T_DEST_DEAD,
                                                    pwdata[7:4]);
                    endcase
                    if (pwdata[3:0] == 4'h4) begin
                        dead_pending_reg <= 1'b1;
                        dead_leader_reg <= (pwdata[11:8] != 4'h0 && pwdata[11:8] <= 4'h4 ||
                                            pwdata[11:8] == 4'hf) ?
                                           put(rx_leader_reg, BIT_MSGID_HI, 12,
                                               16'(MSGID_UNKNOWN)) : rx_leader_reg;
                        dead_sub_reg <= pwdata[11:8];
                    end
                end
            end
            // type 10 waits until the ready line is back up
            if (wr && paddr == A_CTRL && ready_reg && !pwdata[0]) begin
                reset_pending_reg <= 1'b1;
            end
        end
    end

    assign tx_valid = tx_busy_reg;
    assign tx_bit = tx_sr_reg[95];
    assign tx_last = tx_busy_reg && tx_cnt_reg == 7'(LEADER_BITS - 1);

    // ****************************************
    // event flags, set wins over clear
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            event_reg <= '0;
        end else begin
            event_reg <= ((wr && paddr == A_EVENT) ? (event_reg & ~pwdata[7:0]) : event_reg)
                         | event_next;
        end
    end

    // ****************************************
    // apb read path and status
    // ****************************************
    always_comb begin
        prdata = 32'h0;
        pslverr = 1'b0;
        if (paddr == A_CTRL) begin
            prdata = {31'h0, ready_reg};
        end else if (paddr == A_LOCAL) begin
            prdata = {8'h0, local_host_reg, local_node_reg};
        end else if (paddr == A_RX_W0) begin
            prdata = rx_leader_reg[95:64];
        end else if (paddr == A_RX_W1) begin
            prdata = rx_leader_reg[63:32];
        end else if (paddr == A_RX_W2) begin
            prdata = rx_leader_reg[31:0];
        end else if (paddr == A_TX_W0) begin
            prdata = tx_leader_reg[95:64];
        end else if (paddr == A_TX_W1) begin
            prdata = tx_leader_reg[63:32];
        end else if (paddr == A_TX_W2) begin
            prdata = tx_leader_reg[31:0];
        end else if (paddr == A_EVENT) begin
            prdata = {24'h0, event_reg};
        end else if (paddr == A_STATUS) begin
            // priority, size code applied, pseudo-host, get-ready multi-packet
            prdata = {17'h0, lsub == 4'h2 && (get(rx_leader_reg, BIT_LEN_HI, 16) == 16'h0 ||
                      get(rx_leader_reg, BIT_LEN_HI, 16) > 16'(PACKET_BITS)),
                      8'(get(rx_leader_reg, BIT_HOST_HI, 8)) >= PSEUDO_HOST_MIN,
                      DEFAULT_SIZE_CODE, rx_leader_reg[95 - BIT_PRIO + 1],
                      dead_pending_reg, tx_busy_reg, error_reg, 1'b0,
                      2'(rx_state_reg), 3'h0};
        end else if (paddr == A_CMD) begin
            prdata = 32'h0;
        end else begin
            pslverr = psel && penable;
        end
    end
endmodule

// >>> hnlc_codec_asserts.sv
`timescale 1ns/100ps
module hnlc_codec_asserts
    import hnlc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_valid,
    input wire logic rx_bit,
    input wire logic rx_last,
    input wire logic rx_host_error,
    input wire logic tx_valid,
    input wire logic tx_bit,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic node_ready,
    input wire logic node_error
);
    // ****************************************
    // leader position and type tracking
    // ****************************************
    logic [6:0] pos_reg;
    logic [7:0] type_reg;
    wire take = tx_valid && tx_ready;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos_reg <= 7'h00;
        end else if (!node_ready || (take && tx_last)) begin
            pos_reg <= 7'h00;
        end else if (take) begin
            pos_reg <= pos_reg + 7'h01;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            type_reg <= 8'h00;
        end else if (take && pos_reg >= 7'd24 && pos_reg < 7'd32) begin
            type_reg <= {type_reg[6:0], tx_bit};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // ****************************************
    // checks
    // ****************************************
    a_pready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (psel && penable && paddr > A_CMD |-> pslverr)
        else $error("no slverr on unmapped access");
    a_mapped_ok: assert property (psel && penable && paddr <= A_CMD && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("slverr on mapped access");
    a_bit_holds: assert property (tx_valid && !tx_ready && !psel
        |=> !node_ready || (tx_valid && $stable(tx_bit) && $stable(tx_last)))
        else $error("tx bit changed while stalled");
    a_last_pos: assert property (tx_valid && tx_last |-> pos_reg == 7'd95)
        else $error("last flag not on bit 96");
    a_last_valid: assert property (tx_last |-> tx_valid)
        else $error("last flag without valid");
    a_start_ready: assert property ($rose(tx_valid) |-> node_ready)
        else $error("transmit started while not ready");
    a_err_on_drop: assert property ($fell(node_ready) |-> ##[0:2] node_error)
        else $error("error flag not set on ready drop");
    a_ready_write: assert property (psel && penable && pwrite && paddr == A_CTRL
        |=> node_ready == $past(pwdata[0])) else $error("ready line not written");
    a_dead_prio: assert property (take && pos_reg == 7'd32 && type_reg == T_DEAD_STATUS
        |-> !tx_bit) else $error("dead status priority bit set");
    a_nop_sub: assert property (take && pos_reg >= 7'd76 && pos_reg <= 7'd79
        && type_reg == T_NOP |-> !tx_bit) else $error("nop sub-type not zero");
    c_nop: cover property (take && pos_reg == 7'd32 && type_reg == T_NOP);
    c_dead: cover property (take && pos_reg == 7'd32 && type_reg == T_DEAD_STATUS);
    c_drop: cover property ($fell(node_ready));
    c_slverr: cover property (pslverr);
endmodule

bind hnlc_codec hnlc_codec_asserts u_chk (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .rx_last(rx_last), .rx_host_error(rx_host_error), .tx_valid(tx_valid),
    .tx_bit(tx_bit), .tx_last(tx_last), .tx_ready(tx_ready), .node_ready(node_ready),
    .node_error(node_error));

// >>> hnlc_codec_bench.sv
`timescale 1ns/100ps
module hnlc_codec_bench
    import hnlc_pkg::*;
;
    logic clk = 1'b0;
    logic rstn, psel, penable, pwrite, pready, pslverr, slv_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic rx_valid, rx_bit, rx_last, rx_host_error, tx_valid, tx_bit, tx_last, tx_ready;
    logic node_ready, node_error;
    logic [95:0] got;
    logic [3:0] dcode[4] = '{4'h0, 4'h1, 4'h3, 4'h0};
    logic [3:0] dsub[4] = '{4'h1, 4'hf, 4'h4, 4'h5};
    int bad_count = 0;
    int compares = 0;
    always #5 clk = ~clk;
    hnlc_codec #(.XMIT_LIMIT(9000)) dut (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_bit(rx_bit), .rx_last(rx_last), .rx_host_error(rx_host_error),
        .tx_valid(tx_valid), .tx_bit(tx_bit), .tx_last(tx_last), .tx_ready(tx_ready),
        .node_ready(node_ready), .node_error(node_error));
    hnlc_host_model host (.clk(clk), .tx_valid(tx_valid), .tx_bit(tx_bit),
        .tx_last(tx_last), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .rx_last(rx_last), .rx_host_error(rx_host_error));
    // ****************************************
    // helpers
    // ****************************************
    task automatic conclude;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            bad_count++;
            conclude();
        end
        rd = prdata;
        slv_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic get;
        for (int n = 0; n < 3000 && host.q.size() == 0; n++) begin
            @(posedge clk);
        end
        if (host.q.size() == 0) begin
            bad_count++;
            conclude();
        end
        got = host.q.pop_front();
    endtask
    task automatic rep(input logic [7:0] t, input logic [3:0] s);
        get();
        chk(got[71:64], t);
        chk(got[19:16], s);
    endtask
    function automatic logic [95:0] mk(logic [7:0] t, logic [3:0] s, logic [2:0] sz);
        mk = '0;
        mk[91:88] = NEW_FORMAT;
        mk[71:64] = t;
        mk[58:56] = sz;
        mk[55:32] = 24'h210b0c;
        mk[31:20] = 12'h5a3;
        mk[19:16] = s;
        mk[15:0] = 16'h0010;
    endfunction
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        chk(node_ready, 1'b0);
        chk(node_error, 1'b0);
        chk(tx_valid, 1'b0);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, A_LOCAL, 32'h00123456);
        apb(1'b0, A_LOCAL, 32'h0);
        chk(rd, 32'h00123456);
        apb(1'b1, A_CTRL, 32'h1);
        apb(1'b0, 8'h2c, 32'h0);
        chk(slv_seen, 1'b1);
        host.slow <= 1'b1;
        apb(1'b1, A_CMD, 32'h1);
        rep(T_NOP, 4'h0);
        chk(got[55:32], 24'h123456);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_CMD, {20'h0, dsub[i], dcode[i], 4'h4});
            rep(T_DEST_DEAD, dcode[i]);
            rep(T_DEAD_STATUS, dsub[i]);
            chk(got[63], 1'b0);
            chk(got[31:20], (dsub[i] == 4'h5) ? 12'h0 : MSGID_UNKNOWN);
        end
        apb(1'b1, A_CMD, 32'h3);
        rep(T_REFUSED, 4'h0);
        apb(1'b1, A_CMD, 32'h2);
        rep(T_ACK, 4'h0);
        host.slow <= 1'b0;
        host.send(mk(T_REGULAR, 4'h3, 3'h7), 96, 0, 16);
        apb(1'b0, A_RX_W0, 32'h0);
        chk(rd, 32'h0f000000);
        apb(1'b0, A_RX_W1, 32'h0);
        chk(rd, 32'h07210b0c);
        apb(1'b0, A_RX_W2, 32'h0);
        chk(rd, 32'h5a330010);
        apb(1'b0, A_EVENT, 32'h0);
        chk(rd[1], 1'b1);
        apb(1'b1, A_EVENT, 32'h7);
        apb(1'b0, A_EVENT, 32'h0);
        chk(rd[2:0], 3'h0);
        host.send(mk(T_REGULAR, 4'h0, 3'h0), 96, 0, 2016);
        repeat (50) @(posedge clk);
        chk(96'(host.q.size()), 96'h0);
        host.send(mk(T_REGULAR, 4'h0, 3'h7), 96, 0, 8065);
        rep(T_INCOMPLETE, 4'h1);
        host.send(mk(T_REGULAR, 4'h0, 3'h7), 96, 9010, 8);
        rep(T_INCOMPLETE, 4'h2);
        host.send(mk(T_REGULAR, 4'h0, 3'h7), 20, 0, 0);
        rep(T_ERR_LEADER, 4'h1);
        host.send(mk(8'h03, 4'h0, 3'h7), 96, 0, 0);
        rep(T_ERR_LEADER, 4'h2);
        fork
            host.send(mk(T_REGULAR, 4'h0, 3'h7), 96, 20, 8);
            begin
                repeat (100) @(posedge clk);
                host.pulse_err();
            end
        join
        rep(T_ERR_DATA, 4'h0);
        apb(1'b1, A_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        chk(node_error, 1'b1);
        apb(1'b1, A_CTRL, 32'h1);
        host.send(mk(T_REGULAR, 4'h0, 3'h7), 96, 0, 8);
        get();
        chk(got[71:64], T_IF_RESET);
        get();
        chk(got[79:64] & 16'h00ff, {8'h00, T_ERR_LEADER});
        chk(got[19:16], 4'h0);
        host.pulse_err();
        apb(1'b0, A_EVENT, 32'h0);
        chk(rd[2], 1'b1);
        conclude();
    end
endmodule

// >>> hnlc_host_model.sv
`timescale 1ns/100ps
module hnlc_host_model (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic tx_bit,
    input wire logic tx_last,
    output logic tx_ready,
    output logic rx_valid,
    output wire logic rx_bit,
    output logic rx_last,
    output logic rx_host_error
);
    logic [95:0] q[$];
    logic [95:0] sh;
    logic [31:0] cyc = 32'h0;
    logic slow = 1'b0;
    logic dbit = 1'b0;
    logic tog = 1'b0;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_host_error = 1'b0;
    end
    // idle line changes every cycle
    assign rx_bit = rx_valid ? dbit : tog;
    // ****************************************
    // leader capture, bit 1 first
    // ****************************************
    always @(posedge clk) begin
        tog <= ~tog;
        cyc <= cyc + 32'h1;
        tx_ready <= !slow || (cyc[1:0] != 2'b00);
        if (tx_valid && tx_ready) begin
            sh = {sh[94:0], tx_bit};
            if (tx_last) begin
                q.push_back(sh);
            end
        end
    end
    task automatic send(input logic [95:0] l, input int nlead, input int gap, input int body);
        for (int i = 0; i < nlead + body; i++) begin
            if (i == nlead) begin
                repeat (gap) begin
                    @(posedge clk);
                    rx_valid <= 1'b0;
                end
            end
            @(posedge clk);
            rx_valid <= 1'b1;
            dbit <= (i < nlead) ? l[95 - i] : i[0];
            rx_last <= (i == nlead + body - 1);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask
    task automatic pulse_err;
        @(posedge clk);
        rx_host_error <= 1'b1;
        @(posedge clk);
        rx_host_error <= 1'b0;
    endtask
endmodule

// >>> hnlc_pkg.sv
package hnlc_pkg;
    // ****************************************
    // leader field positions (bit 1 sent first)
    // ****************************************
    localparam int LEADER_BITS = 96;
    localparam int BIT_FMT_HI = 5;
    localparam int BIT_TYPE_HI = 25;
    localparam int BIT_PRIO = 33;
    localparam int BIT_UNAS_HI = 34;
    localparam int BIT_SIZE_HI = 38;
    localparam int BIT_HOST_HI = 41;
    localparam int BIT_NODE_HI = 49;
    localparam int BIT_MSGID_HI = 65;
    localparam int BIT_SUB_HI = 77;
    localparam int BIT_LEN_HI = 81;
    localparam logic [3:0] NEW_FORMAT = 4'hf;
    localparam int PACKET_BITS = 1008;
    localparam logic [2:0] DEFAULT_SIZE_CODE = 3'h7;
    localparam logic [7:0] PSEUDO_HOST_MIN = 8'hfc;
    localparam logic [11:0] MSGID_UNKNOWN = 12'hffe;
    localparam int SHORT_BITS = 32;
    // ****************************************
    // message types
    // ****************************************
    localparam logic [7:0] T_REGULAR = 8'h00;
    localparam logic [7:0] T_ERR_LEADER = 8'h01;
    localparam logic [7:0] T_GOING_DOWN = 8'h02;
    localparam logic [7:0] T_NOP = 8'h04;
    localparam logic [7:0] T_ACK = 8'h05;
    localparam logic [7:0] T_DEAD_STATUS = 8'h06;
    localparam logic [7:0] T_DEST_DEAD = 8'h07;
    localparam logic [7:0] T_ERR_DATA = 8'h08;
    localparam logic [7:0] T_INCOMPLETE = 8'h09;
    localparam logic [7:0] T_IF_RESET = 8'h0a;
    localparam logic [7:0] T_REFUSED = 8'h0b;
    // ****************************************
    // apb register map
    // ****************************************
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_LOCAL = 8'h04;
    localparam logic [7:0] A_RX_W0 = 8'h08;
    localparam logic [7:0] A_RX_W1 = 8'h0c;
    localparam logic [7:0] A_RX_W2 = 8'h10;
    localparam logic [7:0] A_TX_W0 = 8'h14;
    localparam logic [7:0] A_TX_W1 = 8'h18;
    localparam logic [7:0] A_TX_W2 = 8'h1c;
    localparam logic [7:0] A_EVENT = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [7:0] A_CMD = 8'h28;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int XMIT_LIMIT_SEC = 15;
    localparam longint XMIT_LIMIT_CYC = longint'(XMIT_LIMIT_SEC) * CLK_MHZ * 1000000;
    typedef enum logic [1:0] {
        HNLC_IDLE = 2'b00,
        HNLC_LEADER = 2'b01,
        HNLC_BODY = 2'b10,
        HNLC_DROP = 2'b11
    } hnlc_rx_t;
endpackage
